// [io_zone_pkg.sv]
/*
 * Constants for the host I/O window decoder: register indices, field
 * positions, reset values and fixed decode addresses.
 * Assumes registers sit one per aligned 32-bit APB word, byte address
 * equal to four times the register index.
 */
package io_zone_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is index times four)
    // ------------------------------------------------------------------
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_CONFIG = 8'hF0;
    localparam logic [7:0] IDX_A_HIGH = 8'hF1;
    localparam logic [7:0] IDX_A_LOW = 8'hF2;
    localparam logic [7:0] IDX_A_SIZE = 8'hF3;
    localparam logic [7:0] IDX_B_HIGH = 8'hF4;
    localparam logic [7:0] IDX_B_LOW = 8'hF5;
    localparam logic [7:0] IDX_B_SIZE = 8'hF6;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_LOCK_BIT = 7;
    localparam int CFG_DEBUG_BIT = 4;
    localparam int CFG_EN_LSB = 0;
    localparam int NUM_WINDOWS = 4;
    localparam int SIZE_W = 4;
    localparam int ADDR_W = 16;

    // ------------------------------------------------------------------
    // Reset values and fixed addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] BASE_RST = 8'h00;
    localparam logic [3:0] SIZE_RST = 4'h0;
    localparam logic [3:0] SIZE_MAX_CODE = 4'h8;
    localparam logic [15:0] DEBUG_PORT_ADDR = 16'h0080;

endpackage : io_zone_pkg

// [io_window_match.sv]
/*
 * Single I/O window comparator: power-of-two window at a given base.
 * Assumes the base is aligned to the window size by software.
 */
`timescale 1ns/1ps
module io_window_match
    import io_zone_pkg::*;
(
    input wire logic [ADDR_W-1:0] window_base,
    input wire logic [SIZE_W-1:0] size_code,
    input wire logic window_enable,
    input wire logic [ADDR_W-1:0] cycle_addr,
    output logic window_hit
);

    // ------------------------------------------------------------------
    // Compare address bits above the size bits
    // ------------------------------------------------------------------
    wire logic [ADDR_W-1:0] span_mask;

    assign span_mask = 16'hFFFF << size_code;
    assign window_hit = window_enable &&
        ((cycle_addr & span_mask) == (window_base & span_mask));

endmodule : io_window_match

// [io_zone_window_decoder.sv]
/*
 * Host I/O window decoder: APB register file for two window pairs,
 * enables and map lock, and claim decode of host I/O cycle addresses.
 * Assumes host I/O cycles arrive as a one-cycle valid with a 16-bit
 * address, synchronous to pclk.
 */
// The implementer's own choice: the APB slave port.
// What this block does
// R1 - Pair A base is high byte bits 15:8 plus low byte bits 7:0.
// R2 - Pair A low-byte register gives base address bits 7:0.
// R3 - Pair B base is formed the same way from its own registers.
// R4 - Size field bits 3:0 gives window length two to the n bytes.
// R5 - Code 0 is one byte default, code 8 is 256; above 8 reserved.
// R6 - Software aligns each base to its window size.
// R7 - Both windows of a pair share size and are contiguous.
// R8 - Second window address never depends on first window enable.
// R9 - All base and size registers reset to zero.
// R10 - First window at base, second at base plus window size.
// R11 - Each window claims only when its own enable is set.
// R12 - Lock set makes all base, size and config writes ignored.
// R13 - Claim host I/O cycle whose address hits any enabled window.
// R14 - Size register bits 7:4 read zero and never affect decode.
`timescale 1ns/1ps
module io_zone_window_decoder
    import io_zone_pkg::*;
#(
    parameter int PADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic io_cycle_valid,
    input wire logic [ADDR_W-1:0] io_cycle_addr,
    output logic io_claim,
    output logic [NUM_WINDOWS-1:0] io_claim_window,
    output logic io_claim_debug
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic io_map_lock_r;
    logic debug_port_enable_r;
    logic [NUM_WINDOWS-1:0] window_enable_r;
    logic [7:0] pair_a_base_upper_field_r;
    logic [7:0] pair_a_base_lower_field_r;
    logic [SIZE_W-1:0] pair_a_size_code_r;
    logic [7:0] pair_b_base_upper_field_r;
    logic [7:0] pair_b_base_lower_field_r;
    logic [SIZE_W-1:0] pair_b_size_code_r;
    logic [31:0] prdata_r;
    logic io_claim_r;
    logic [NUM_WINDOWS-1:0] io_claim_window_r;
    logic io_claim_debug_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic [IDX_W-1:0] reg_idx = paddr[IDX_W+1:2];
    wire logic upper_zero = (paddr >> (IDX_W + 2)) == '0;
    wire logic sel_config = upper_zero && (reg_idx == IDX_CONFIG);
    wire logic sel_a_high = upper_zero && (reg_idx == IDX_A_HIGH);
    wire logic sel_a_low = upper_zero && (reg_idx == IDX_A_LOW);
    wire logic sel_a_size = upper_zero && (reg_idx == IDX_A_SIZE);
    wire logic sel_b_high = upper_zero && (reg_idx == IDX_B_HIGH);
    wire logic sel_b_low = upper_zero && (reg_idx == IDX_B_LOW);
    wire logic sel_b_size = upper_zero && (reg_idx == IDX_B_SIZE);
    wire logic addr_mapped = sel_config || sel_a_high || sel_a_low ||
        sel_a_size || sel_b_high || sel_b_low || sel_b_size;
    wire logic setup_phase = psel && !penable;
    wire logic access_phase = psel && penable;
    wire logic wr_ok = access_phase && pwrite && !io_map_lock_r; // R12
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic [7:0] config_byte;
    wire logic [7:0] rd_byte;

    assign config_byte = {io_map_lock_r, 2'b00, debug_port_enable_r,
        window_enable_r};
    assign rd_byte =
        sel_config ? config_byte :
        sel_a_high ? pair_a_base_upper_field_r :
        sel_a_low ? pair_a_base_lower_field_r :
        sel_a_size ? {4'h0, pair_a_size_code_r} : // R14
        sel_b_high ? pair_b_base_upper_field_r :
        sel_b_low ? pair_b_base_lower_field_r :
        sel_b_size ? {4'h0, pair_b_size_code_r} : // R14
        8'h00;

    assign pready = 1'b1;
    assign pslverr = access_phase && !addr_mapped;
    assign prdata = prdata_r;

    // ------------------------------------------------------------------
    // Read data capture in setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata_r <= {24'h00_0000, rd_byte};
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_map_lock_r <= CONFIG_RST[CFG_LOCK_BIT];
            debug_port_enable_r <= CONFIG_RST[CFG_DEBUG_BIT];
            window_enable_r <= CONFIG_RST[NUM_WINDOWS-1:0]; // R11
        end
        else if (wr_ok && sel_config) // R12
        begin
            io_map_lock_r <= wbyte[CFG_LOCK_BIT];
            debug_port_enable_r <= wbyte[CFG_DEBUG_BIT];
            window_enable_r <= wbyte[CFG_EN_LSB +: NUM_WINDOWS];
        end
    end

    // ------------------------------------------------------------------
    // Base and size registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pair_a_base_upper_field_r <= BASE_RST; // R9
            pair_a_base_lower_field_r <= BASE_RST; // R9
            pair_a_size_code_r <= SIZE_RST; // R9
            pair_b_base_upper_field_r <= BASE_RST; // R9
            pair_b_base_lower_field_r <= BASE_RST; // R9
            pair_b_size_code_r <= SIZE_RST; // R9
        end
        else
        begin
            if (wr_ok && sel_a_high)
                pair_a_base_upper_field_r <= wbyte; // R1
            if (wr_ok && sel_a_low)
                pair_a_base_lower_field_r <= wbyte; // R2
            if (wr_ok && sel_a_size)
                pair_a_size_code_r <= wbyte[SIZE_W-1:0]; // R4
            if (wr_ok && sel_b_high)
                pair_b_base_upper_field_r <= wbyte; // R3
            if (wr_ok && sel_b_low)
                pair_b_base_lower_field_r <= wbyte; // R3
            if (wr_ok && sel_b_size)
                pair_b_size_code_r <= wbyte[SIZE_W-1:0]; // R4
        end
    end

    // ------------------------------------------------------------------
    // Window placement
    // ------------------------------------------------------------------
    wire logic [ADDR_W-1:0] pair_a_base = {pair_a_base_upper_field_r,
        pair_a_base_lower_field_r}; // R1 R2
    wire logic [ADDR_W-1:0] pair_b_base = {pair_b_base_upper_field_r,
        pair_b_base_lower_field_r}; // R3
    wire logic [ADDR_W-1:0] pair_a_len;
    wire logic [ADDR_W-1:0] pair_b_len;
    wire logic [ADDR_W-1:0] win_base [NUM_WINDOWS];
    wire logic [SIZE_W-1:0] win_size [NUM_WINDOWS];
    wire logic [NUM_WINDOWS-1:0] win_hit;

    assign pair_a_len = 16'h0001 << pair_a_size_code_r; // R4 R5
    assign pair_b_len = 16'h0001 << pair_b_size_code_r; // R4 R5
    assign win_base[0] = pair_a_base; // R10
    assign win_base[1] = pair_a_base + pair_a_len; // R7 R8 R10
    assign win_base[2] = pair_b_base; // R10
    assign win_base[3] = pair_b_base + pair_b_len; // R7 R8 R10
    assign win_size[0] = pair_a_size_code_r; // R7
    assign win_size[1] = pair_a_size_code_r; // R7
    assign win_size[2] = pair_b_size_code_r; // R7
    assign win_size[3] = pair_b_size_code_r; // R7

    // ------------------------------------------------------------------
    // Per-window match
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_WINDOWS; i++)
        begin : g_window
            io_window_match u_match (
                .window_base(win_base[i]),
                .size_code(win_size[i]),
                .window_enable(window_enable_r[i]), // R11
                .cycle_addr(io_cycle_addr),
                .window_hit(win_hit[i])
            );
        end
    endgenerate

    wire logic debug_hit = debug_port_enable_r &&
        (io_cycle_addr == DEBUG_PORT_ADDR);

    // ------------------------------------------------------------------
    // Claim outputs, one cycle after the cycle address
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            io_claim_r <= 1'b0;
            io_claim_window_r <= '0;
            io_claim_debug_r <= 1'b0;
        end
        else
        begin
            io_claim_r <= io_cycle_valid && ((|win_hit) || debug_hit); // R13
            io_claim_window_r <= io_cycle_valid ? win_hit : '0; // R13
            io_claim_debug_r <= io_cycle_valid && debug_hit;
        end
    end

    assign io_claim = io_claim_r;
    assign io_claim_window = io_claim_window_r;
    assign io_claim_debug = io_claim_debug_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    wire logic [ADDR_W-1:0] top_w0 = pair_a_base + pair_a_len - 16'h0001;
    wire logic [ADDR_W-1:0] base_w1 = pair_a_base + pair_a_len;
    wire logic [ADDR_W-1:0] top_w1 = base_w1 + pair_a_len - 16'h0001;
    wire logic aligned_a = (pair_a_base & (pair_a_len - 16'h0001)) == '0;

    property p_base_high;
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel_a_high |=> pair_a_base[15:8] == $past(pwdata[7:0]);
    endproperty
    a_base_high: assert property (p_base_high) // R1
        else $error("pair A high byte not written");
    property p_base_low;
        @(posedge pclk) disable iff (!presetn)
        wr_ok && sel_a_low |=> pair_a_base[7:0] == $past(pwdata[7:0]);
    endproperty
    a_base_low: assert property (p_base_low) // R2
        else $error("pair A low byte not written");

    property p_pair_b;
        @(posedge pclk) disable iff (!presetn)
        io_cycle_valid && window_enable_r[2] && io_cycle_addr == pair_b_base
        |=> io_claim_window[2] && io_claim;
    endproperty
    a_pair_b: assert property (p_pair_b) // R3
        else $error("pair B base not claimed");

    property p_size_top;
        @(posedge pclk) disable iff (!presetn)
        io_cycle_valid && window_enable_r[0] &&
        pair_a_size_code_r <= SIZE_MAX_CODE && io_cycle_addr == top_w0 &&
        aligned_a
        |=> io_claim_window[0];
    endproperty
    a_size_top: assert property (p_size_top) // R4
        else $error("last byte of window 0 not claimed");
    property p_one_byte;
        @(posedge pclk) disable iff (!presetn)
        io_cycle_valid && pair_a_size_code_r == 4'h0 &&
        io_cycle_addr == pair_a_base + 16'h0001
        |=> !io_claim_window[0];
    endproperty
    a_one_byte: assert property (p_one_byte) // R5
        else $error("size code 0 claimed more than one byte");

    property p_second_top;
        @(posedge pclk) disable iff (!presetn)
        io_cycle_valid && window_enable_r[1] &&
        pair_a_size_code_r <= SIZE_MAX_CODE && aligned_a &&
        io_cycle_addr == top_w1
        |=> io_claim_window[1];
    endproperty
    a_second_top: assert property (p_second_top) // R7
        else $error("second window not of equal size");
    property p_second_alone;
        @(posedge pclk) disable iff (!presetn)
        io_cycle_valid && window_enable_r[1] && !window_enable_r[0] &&
        io_cycle_addr == base_w1
        |=> io_claim_window[1] && !io_claim_window[0];
    endproperty
    a_second_alone: assert property (p_second_alone) // R8 R10
        else $error("second window moved with first enable");

    property p_reset_zero;
        @(posedge pclk) $rose(presetn) |->
        pair_a_base == 16'h0000 && pair_b_base == 16'h0000 &&
        pair_a_size_code_r == 4'h0 && pair_b_size_code_r == 4'h0;
    endproperty
    a_reset_zero: assert property (p_reset_zero) // R9
        else $error("window registers not zero after reset");

    property p_no_enable;
        @(posedge pclk) disable iff (!presetn)
        window_enable_r == 4'h0 ##1 1'b1 |-> io_claim_window == 4'h0;
    endproperty
    a_no_enable: assert property (p_no_enable) // R11
        else $error("window claimed while disabled");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        io_map_lock_r && access_phase && pwrite
        |=> $stable(pair_a_base) && $stable(pair_b_base) &&
        $stable(pair_a_size_code_r) && $stable(pair_b_size_code_r) &&
        $stable(window_enable_r) && io_map_lock_r;
    endproperty
    a_lock: assert property (p_lock) // R12
        else $error("write took effect while map locked");
    property p_claim_or;
        @(posedge pclk) disable iff (!presetn)
        io_claim == ((|io_claim_window) || io_claim_debug);
    endproperty
    a_claim_or: assert property (p_claim_or) // R13
        else $error("claim disagrees with window hits");

    property p_size_read;
        @(posedge pclk) disable iff (!presetn)
        setup_phase && !pwrite && (sel_a_size || sel_b_size)
        |=> prdata[31:4] == 28'h000_0000;
    endproperty
    a_size_read: assert property (p_size_read) // R14
        else $error("reserved size bits read nonzero");

    c_claim_w0: cover property (@(posedge pclk) io_claim_window[0]);
    c_claim_w3: cover property (@(posedge pclk) io_claim_window[3]);
    c_lock_write: cover property (@(posedge pclk)
        io_map_lock_r && access_phase && pwrite);
    c_size_max: cover property (@(posedge pclk)
        pair_b_size_code_r == SIZE_MAX_CODE && io_claim_window[3]);

endmodule : io_zone_window_decoder

// [io_host_model.sv]
/*
 * Host side model issuing I/O cycle addresses as one-cycle valid pulses.
 * Assumes a free-running pclk; the bench calls send() for each cycle.
 */
`timescale 1ns/1ps
module io_host_model
    import io_zone_pkg::*;
(
    input wire logic pclk,
    output logic io_cycle_valid,
    output logic [ADDR_W-1:0] io_cycle_addr
);
    // ------------------------------------------------------------------
    // Cycle issue
    // ------------------------------------------------------------------
    logic req_r = 1'b0;
    logic [ADDR_W-1:0] req_addr_r = 16'h0000;

    initial
    begin
        io_cycle_valid = 1'b0;
        io_cycle_addr = 16'h0000;
    end

    // Idle address flips each cycle so stale values never match
    always @(posedge pclk)
    begin
        io_cycle_valid <= req_r;
        io_cycle_addr <= req_r ? req_addr_r : ~io_cycle_addr;
    end

    // Returns just after the edge at which the decoder samples the cycle
    task automatic send(input logic [ADDR_W-1:0] a, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        req_r <= 1'b1;
        req_addr_r <= a;
        @(posedge pclk);
        req_r <= 1'b0;
        @(posedge pclk);
    endtask : send
endmodule : io_host_model

// [tb_top.sv]
/*
 * Self-checking bench for the I/O window decoder with a register model.
 * Assumes zero-wait APB and claim outputs one cycle after valid.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch at %0t got %h exp %h", $time, got, exp); \
        end \
    end

module tb_top;
    import io_zone_pkg::*;
    // ------------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic io_cycle_valid, io_claim, io_claim_debug, er;
    logic [ADDR_W-1:0] io_cycle_addr;
    logic [NUM_WINDOWS-1:0] io_claim_window;
    int err_total = 0;
    int check_count = 0;
    int seed = 66;
    int mr [7];
    int b, ln, off;

    io_zone_window_decoder #(.PADDR_W(12)) i_io_zone_window_decoder (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .io_cycle_valid(io_cycle_valid), .io_cycle_addr(io_cycle_addr),
        .io_claim(io_claim), .io_claim_window(io_claim_window),
        .io_claim_debug(io_claim_debug));

    io_host_model i_io_host_model (.pclk(pclk),
        .io_cycle_valid(io_cycle_valid), .io_cycle_addr(io_cycle_addr));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        #200000;
        err_total++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    function automatic int slot(input logic [7:0] idx);
        return (idx >= 8'hF0 && idx <= 8'hF6) ? int'(idx) - 'hF0 : -1;
    endfunction : slot

    function automatic int wmask(input int i);
        return (i == 0) ? 'h9F : (i == 3 || i == 6) ? 'h0F : 'hFF;
    endfunction : wmask

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
        begin
            err_total++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic mwr(input logic [7:0] idx, input logic [31:0] d);
        int i;
        i = slot(idx);
        apb(1'b1, idx, d);
        `CHK(er, logic'(i < 0))
        if (i >= 0 && !mr[0][CFG_LOCK_BIT])
            mr[i] = d & wmask(i);
    endtask : mwr

    task automatic mchk(input logic [7:0] idx);
        int i;
        i = slot(idx);
        apb(1'b0, idx, 32'h0);
        `CHK(rd, (i < 0) ? 32'h0 : 32'(mr[i]))
        `CHK(er, logic'(i < 0))
    endtask : mchk

    function automatic logic [4:0] exp_claim(input int a);
        int bs, n, s;
        exp_claim = 5'h00;
        for (int p = 0; p < 2; p++)
        begin
            bs = (mr[1 + 3 * p] << 8) | mr[2 + 3 * p];
            n = mr[3 + 3 * p] & 15;
            for (int w = 0; w < 2; w++)
            begin
                s = (bs + w * (1 << n)) & 'hFFFF;
                if (mr[0][2 * p + w] && (a >> n) == (s >> n))
                    exp_claim[2 * p + w] = 1'b1;
            end
        end
        exp_claim[4] = mr[0][CFG_DEBUG_BIT] && a == 'h80;
    endfunction : exp_claim

    task automatic probe(input logic [ADDR_W-1:0] a);
        logic [4:0] e;
        e = exp_claim(int'(a));
        i_io_host_model.send(a, $random(seed) & 3);
        #1;
        `CHK({io_claim_debug, io_claim_window}, e)
        `CHK(io_claim, |e)
    endtask : probe

    task automatic chk_all();
        for (int i = 0; i < 8; i++)
            mchk(8'hF0 + i[7:0]);
    endtask : chk_all

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        foreach (mr[i]) mr[i] = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        mchk(8'h10);
        for (int i = 1; i < 7; i++)
            mwr(8'hF0 + i[7:0],
                $random(seed) & ~((i % 3 == 0) ? 32'h8 : 32'h0));
        chk_all();
        for (int n = 0; n < 9; n++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                ln = p ? 8 - n : n;
                b = $random(seed) & ('hFFFF << ln);
                mwr(8'(8'hF1 + 3 * p), b >> 8);
                mwr(8'(8'hF2 + 3 * p), b & 'hFF);
                mwr(8'(8'hF3 + 3 * p), ln | 'hF0);
            end
            mwr(8'hF0, (n == 4) ? 'h0A : $random(seed) & 'h1F);
            for (int p = 0; p < 2; p++)
            begin
                b = (mr[1 + 3 * p] << 8) | mr[2 + 3 * p];
                ln = 1 << (mr[3 + 3 * p] & 15);
                for (int j = 0; j < 6; j++)
                begin
                    off = (j / 2) * ln - ((j % 2 == 0) ? 1 : 0);
                    probe(16'(b + off));
                end
            end
            probe(16'h0080);
            probe(16'($random(seed)));
        end
        mwr(8'hF0, 'h8F);
        mwr(8'hF1, 'h5A);
        mwr(8'hF3, 'h03);
        mwr(8'hF5, 'hA5);
        mwr(8'hF0, 'h00);
        chk_all();
        probe(16'((mr[1] << 8) | mr[2]));
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (mr[i]) mr[i] = 0;
        chk_all();
        probe(16'h0000);
        wrap_up();
    end
endmodule : tb_top
